// >>> scst_byte_collect.sv
// shift register gathering the value bytes of one object
`timescale 1ns/1ps
module scst_byte_collect #(
	parameter int NBYTES = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic shift,
	input wire logic [7:0] din,
	output logic [8*NBYTES-1:0] vec
);
	// newest byte lands low; longer values simply drop their head
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec <= '0;
		end else if (clear) begin
			vec <= '0;
		end else if (shift) begin
			vec <= {vec[8*NBYTES-9:0], din};
		end
	end
endmodule

// >>> scst_card.sv
// card end: parses start and terminate commands, answers status
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "scst_defs.svh"
module scst_card
	import scst_pkg::*;
#(
	parameter int SESSIONS = 4,
	parameter logic [15:0] MAX_CONT = 16'h00ff
) (
	input wire logic hclk,
	input wire logic hresetn,
	scst_link_if.card link,
	output logic term_valid,
	output logic term_is_master,
	output logic [127:0] term_ident,
	output logic [127:0] term_mac,
	input wire logic term_mac_ok,
	input wire logic term_exists,
	input wire logic term_done,
	output logic bind_valid,
	output logic [1:0] bind_session,
	output logic [15:0] bind_size,
	output logic [127:0] connection_assoc_ident,
	output logic [127:0] start_channel_auth_code,
	output logic [7:0] cipher_select_byte,
	output logic [7:0] integrity_select_byte,
	input wire logic [1:0] xfer_session,
	output logic [15:0] xfer_size
);
	scst_card_state_t st;
	scst_parse_state_t ps;
	logic [7:0] op, blk_rem, outer_rem, obj_rem, obj_len, tag;
	logic obj_end, p12_bad, fetch, bad_list, sel_ok, mac_bad, fail;
	logic saw_msa, saw_any, rsp_pend;
	logic seen_sel, seen_csa, seen_mac, seen_size;
	logic [1:0] sess, rsp_sess, rsp_idx;
	logic [15:0] size_tab [SESSIONS];
	logic [15:0] cont_size;
	logic [255:0] vec;
	logic [7:0] b;
	logic acc, complete, new_stream, end_now, start_ok, ans_start;
	logic p1_ok, send_end;

	// exactly one defined selection bit, none reserved
	function automatic logic sel_one(input logic [7:0] x);
		sel_one = (x != 8'h00) && ((x & (x - 8'h01)) == 8'h00) &&
			((x & `SCST_SEL_RSVD) == 8'h00);
	endfunction

	assign b = link.tx_data;
	assign acc = link.tx_valid & link.tx_ready;
	assign complete = (ps == PS_TAG) && (outer_rem == 8'h00);
	assign p1_ok = (link.cmd_p1 == `SCST_P1_START) ||
		(link.cmd_p1 == `SCST_P1_TERM);
	// a fresh command stream restarts the parser; blocks otherwise chain
	assign new_stream = (st == CS_IDLE) && link.cmd_start && p1_ok &&
		(link.cmd_p2 == `SCST_P2_CMD) &&
		(ps == PS_BAD || complete || link.cmd_p1 != op);
	assign end_now = acc && ((ps == PS_LEN && b == 8'h00 && b < outer_rem)
		|| (ps == PS_VAL && obj_rem == 8'h01));
	assign start_ok = complete && !bad_list && sel_ok && seen_sel &&
		seen_csa && seen_mac && seen_size && op == `SCST_P1_START;
	assign ans_start = (st == CS_ANSWER) && !p12_bad && !fetch && start_ok;
	assign send_end = (st == CS_SEND) && link.rsp_valid &&
		link.rsp_ready && rsp_idx == 2'h2;
	assign term_ident = vec[`SCST_V_HI];
	assign term_mac = vec[`SCST_V_LO];

	scst_byte_collect #(.NBYTES(32)) u_col (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(acc && ps == PS_TAG),
		.shift(acc && ps == PS_VAL),
		.din(b),
		.vec(vec)
	);

	// command sequencing and response streaming
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= CS_IDLE;
			op <= 8'h00;
			blk_rem <= 8'h00;
			p12_bad <= 1'b0;
			fetch <= 1'b0;
			rsp_idx <= 2'h0;
			link.tx_ready <= 1'b0;
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
		end else begin
			case (st)
			CS_IDLE: begin
				if (link.cmd_start) begin
					p12_bad <= 1'b0;
					fetch <= 1'b0;
					blk_rem <= link.cmd_len;
					if (link.cmd_p2 == `SCST_P2_CMD && p1_ok) begin
						op <= link.cmd_p1;
						if (link.cmd_len == 8'h00) begin
							st <= CS_CHECK;
						end else begin
							st <= CS_RECV;
							link.tx_ready <= 1'b1;
						end
					end else if (link.cmd_p2 == `SCST_P2_RSP && p1_ok) begin
						fetch <= 1'b1;
						if (link.cmd_p1 == `SCST_P1_START && rsp_pend) begin
							st <= CS_SEND;
							link.rsp_valid <= 1'b1;
							link.rsp_data <= `SCST_TAG_RSP;
							rsp_idx <= 2'h0;
						end else begin
							st <= CS_ANSWER;
						end
					end else begin
						p12_bad <= 1'b1;
						st <= CS_ANSWER;
					end
				end
			end
			CS_RECV: begin
				if (acc) begin
					blk_rem <= blk_rem - 8'h01;
					if (blk_rem == 8'h01) begin
						link.tx_ready <= 1'b0;
						st <= CS_CHECK;
					end
				end
			end
			CS_CHECK: st <= CS_ANSWER; // last object verdict settles here
			CS_ANSWER: st <= CS_IDLE;
			CS_SEND: begin
				if (link.rsp_valid && link.rsp_ready) begin
					rsp_idx <= rsp_idx + 2'h1;
					if (rsp_idx == 2'h0) begin
						link.rsp_data <= `SCST_RSP_LEN;
					end else if (rsp_idx == 2'h1) begin
						link.rsp_data <= {rsp_sess, `SCST_RSP_RSVD};
					end else begin
						link.rsp_valid <= 1'b0;
						st <= CS_ANSWER;
					end
				end
			end
			default: st <= CS_IDLE;
			endcase
		end
	end

	// tlv walker over the command data, across blocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ps <= PS_OTAG;
			outer_rem <= 8'h00;
			obj_rem <= 8'h00;
			obj_len <= 8'h00;
			tag <= 8'h00;
			obj_end <= 1'b0;
			term_valid <= 1'b0;
			term_is_master <= 1'b0;
		end else begin
			obj_end <= end_now;
			term_valid <= end_now && op == `SCST_P1_TERM;
			if (new_stream) begin
				ps <= PS_OTAG;
				outer_rem <= 8'h00;
			end else if (acc) begin
				case (ps)
				PS_OTAG: begin
					ps <= (b == `SCST_TAG_CMD) ? PS_OLEN : PS_BAD;
				end
				PS_OLEN: begin
					if (b == `SCST_LEN_LONG) begin
						ps <= PS_OLEN2;
					end else if (b <= `SCST_LEN_SHORT_MAX) begin
						outer_rem <= b;
						ps <= PS_TAG;
					end else begin
						ps <= PS_BAD;
					end
				end
				PS_OLEN2: begin
					outer_rem <= b;
					ps <= PS_TAG;
				end
				PS_TAG: begin
					if (outer_rem == 8'h00) begin
						ps <= PS_BAD; // trailing bytes past the container
					end else begin
						tag <= b;
						term_is_master <= (b == `SCST_TAG_MSA);
						outer_rem <= outer_rem - 8'h01;
						ps <= PS_LEN;
					end
				end
				PS_LEN: begin
					outer_rem <= outer_rem - 8'h01;
					obj_len <= b;
					obj_rem <= b;
					if (b >= outer_rem) begin
						ps <= PS_BAD;
					end else begin
						ps <= (b == 8'h00) ? PS_TAG : PS_VAL;
					end
				end
				PS_VAL: begin
					outer_rem <= outer_rem - 8'h01;
					obj_rem <= obj_rem - 8'h01;
					if (obj_rem == 8'h01) begin
						ps <= PS_TAG;
					end
				end
				default: ps <= PS_BAD;
				endcase
			end
		end
	end

	// object checks; verdict inputs are sampled while term_valid is high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{seen_sel, seen_csa, seen_mac, seen_size} <= 4'h0;
			{bad_list, sel_ok, mac_bad, fail, saw_msa, saw_any} <= 6'h00;
			cipher_select_byte <= 8'h00;
			integrity_select_byte <= 8'h00;
			connection_assoc_ident <= 128'h0;
			start_channel_auth_code <= 128'h0;
			cont_size <= 16'h0000;
		end else if (new_stream) begin
			{seen_sel, seen_csa, seen_mac, seen_size} <= 4'h0;
			{bad_list, sel_ok, mac_bad, fail, saw_msa, saw_any} <= 6'h00;
		end else if (obj_end && op == `SCST_P1_START) begin
			case (tag)
			`SCST_TAG_SEL: begin
				seen_sel <= 1'b1;
				sel_ok <= obj_len == `SCST_LEN_SEL &&
					sel_one(vec[`SCST_V_CIPH]) &&
					sel_one(vec[`SCST_V_INTEG]);
				cipher_select_byte <= vec[`SCST_V_CIPH];
				integrity_select_byte <= vec[`SCST_V_INTEG];
			end
			`SCST_TAG_CSA: begin
				seen_csa <= 1'b1;
				bad_list <= bad_list | (obj_len != `SCST_LEN_ID);
				connection_assoc_ident <= vec[`SCST_V_LO];
			end
			`SCST_TAG_MAC: begin
				seen_mac <= 1'b1;
				bad_list <= bad_list | (obj_len != `SCST_LEN_ID);
				start_channel_auth_code <= vec[`SCST_V_LO];
			end
			`SCST_TAG_SIZE: begin
				seen_size <= 1'b1;
				bad_list <= bad_list | (obj_len == 8'h00) |
					(obj_len > `SCST_LEN_SIZE_MAX) |
					(vec[`SCST_V_SIZE] > MAX_CONT);
				cont_size <= vec[`SCST_V_SIZE];
			end
			default: bad_list <= 1'b1;
			endcase
		end else if (obj_end) begin
			// master alone, or connections only; mixing is refused
			bad_list <= bad_list | (obj_len != `SCST_LEN_ASSOC) |
				saw_msa | (tag == `SCST_TAG_MSA && saw_any) |
				(tag != `SCST_TAG_MSA && tag != `SCST_TAG_CSA);
			saw_any <= 1'b1;
			saw_msa <= saw_msa | (tag == `SCST_TAG_MSA);
			mac_bad <= mac_bad | !term_mac_ok;
			// a missing association is not a failure
			fail <= fail | (term_mac_ok & term_exists & !term_done);
		end
	end

	// status words, one done pulse per command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.done <= 1'b0;
			{link.sw1, link.sw2} <= `SCST_SW_OK;
		end else begin
			link.done <= (st == CS_ANSWER);
			if (st == CS_ANSWER) begin
				if (p12_bad) begin
					{link.sw1, link.sw2} <= `SCST_SW_P1P2;
				end else if (fetch) begin
					{link.sw1, link.sw2} <= `SCST_SW_OK;
				end else if (ps == PS_BAD || bad_list) begin
					{link.sw1, link.sw2} <= `SCST_SW_DATA;
				end else if (!complete) begin
					{link.sw1, link.sw2} <= `SCST_SW_OK;
				end else if (op == `SCST_P1_START) begin
					{link.sw1, link.sw2} <= start_ok ? `SCST_SW_OK :
						`SCST_SW_DATA;
				end else if (mac_bad) begin
					{link.sw1, link.sw2} <= `SCST_SW_MAC;
				end else if (fail) begin
					{link.sw1, link.sw2} <= `SCST_SW_FAIL;
				end else if (!saw_any) begin
					{link.sw1, link.sw2} <= `SCST_SW_DATA;
				end else begin
					{link.sw1, link.sw2} <= `SCST_SW_OK;
				end
			end
		end
	end

	// session assignment and its container size binding
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sess <= 2'h0;
			rsp_sess <= 2'h0;
			rsp_pend <= 1'b0;
			bind_valid <= 1'b0;
			bind_session <= 2'h0;
			bind_size <= 16'h0000;
			xfer_size <= 16'h0000;
			for (int i = 0; i < SESSIONS; i++) begin
				size_tab[i] <= 16'h0000;
			end
		end else begin
			bind_valid <= ans_start;
			xfer_size <= size_tab[xfer_session];
			if (ans_start) begin
				size_tab[sess] <= cont_size;
				bind_session <= sess;
				bind_size <= cont_size;
				rsp_sess <= sess;
				sess <= sess + 2'h1;
				rsp_pend <= 1'b1;
			end else if (send_end || new_stream) begin
				rsp_pend <= 1'b0;
			end
		end
	end
endmodule

// >>> scst_defs.svh
// constants of the secure channel start/terminate command handler
`ifndef SCST_DEFS_SVH
`define SCST_DEFS_SVH
`define SCST_P2_CMD 8'h80
`define SCST_P2_RSP 8'ha0
`define SCST_P1_START 8'h03
`define SCST_P1_TERM 8'h04
`define SCST_TAG_CMD 8'h73
`define SCST_TAG_RSP 8'h53
`define SCST_TAG_SEL 8'h89
`define SCST_TAG_MSA 8'h88
`define SCST_TAG_CSA 8'h8b
`define SCST_TAG_MAC 8'h8d
`define SCST_TAG_SIZE 8'h8e
`define SCST_LEN_SEL 8'h02
`define SCST_LEN_ID 8'h10
`define SCST_LEN_ASSOC 8'h20
`define SCST_LEN_SIZE_MAX 8'h02
`define SCST_LEN_LONG 8'h81
`define SCST_LEN_SHORT_MAX 8'h7f
`define SCST_RSP_LEN 8'h01
`define SCST_RSP_RSVD 6'h00
`define SCST_SEL_RSVD 8'h78
`define SCST_BASIC_CHAN 2'h0
`define SCST_SW_OK 16'h9000
`define SCST_SW_MAC 16'h9862
`define SCST_SW_DATA 16'h6a80
`define SCST_SW_P1P2 16'h6a86
`define SCST_SW_FAIL 16'h6f00
`define SCST_V_CIPH 15:8
`define SCST_V_INTEG 7:0
`define SCST_V_LO 127:0
`define SCST_V_HI 255:128
`define SCST_V_SIZE 15:0
`define SCST_A_CMD 8'h00
`define SCST_A_DATA 8'h04
`define SCST_A_STAT 8'h08
`define SCST_CMD_P1 7:0
`define SCST_CMD_P2 15:8
`define SCST_CMD_LEN 23:16
`define SCST_CMD_CHAN 25:24
`define SCST_ST_SW 15:0
`define SCST_ST_BUSY 16
`define SCST_ST_REFUSED 17
`define SCST_ST_RXAV 18
`endif

// >>> scst_host.sv
// terminal end: ahb-lite register front, issues commands to the card
`timescale 1ns/1ps
`include "scst_defs.svh"
module scst_host
	import scst_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	scst_link_if.host link
);
	logic ph_valid, ph_write, busy, refused, rx_full, cmd_ok;
	logic [7:0] ph_addr, tx_left, rx_byte, c_p1, c_p2;
	logic [1:0] c_chan;
	logic [15:0] sw;

	assign c_p1 = hwdata[`SCST_CMD_P1];
	assign c_p2 = hwdata[`SCST_CMD_P2];
	assign c_chan = hwdata[`SCST_CMD_CHAN];
	// only the two sub-functions, the two block codings, start on ch 0
	assign cmd_ok = !busy &&
		(c_p1 == `SCST_P1_START || c_p1 == `SCST_P1_TERM) &&
		(c_p2 == `SCST_P2_CMD || c_p2 == `SCST_P2_RSP) &&
		!(c_p1 == `SCST_P1_START && c_p2 == `SCST_P2_CMD &&
		c_chan != `SCST_BASIC_CHAN);

	// bus slave: every transfer takes at least one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			refused <= 1'b0;
			tx_left <= 8'h00;
			link.cmd_start <= 1'b0;
			link.cmd_chan <= 2'h0;
			link.cmd_p1 <= 8'h00;
			link.cmd_p2 <= 8'h00;
			link.cmd_len <= 8'h00;
			link.tx_valid <= 1'b0;
			link.tx_data <= 8'h00;
		end else begin
			link.cmd_start <= 1'b0;
			if (!ph_valid && hsel && htrans[1] && hready) begin
				ph_valid <= 1'b1;
				ph_write <= hwrite;
				ph_addr <= haddr[7:0];
				hreadyout <= 1'b0;
			end else if (ph_valid && ph_write && ph_addr == `SCST_A_DATA &&
				tx_left != 8'h00) begin
				// byte stays offered until the card takes it
				if (!link.tx_valid) begin
					link.tx_valid <= 1'b1;
					link.tx_data <= hwdata[7:0];
				end else if (link.tx_ready) begin
					link.tx_valid <= 1'b0;
					tx_left <= tx_left - 8'h01;
					ph_valid <= 1'b0;
					hreadyout <= 1'b1;
				end
			end else if (ph_valid) begin
				ph_valid <= 1'b0;
				hreadyout <= 1'b1;
				hrdata <= 32'h0;
				if (ph_write && ph_addr == `SCST_A_CMD) begin
					refused <= !cmd_ok;
					if (cmd_ok) begin
						link.cmd_start <= 1'b1;
						link.cmd_chan <= c_chan;
						link.cmd_p1 <= c_p1;
						link.cmd_p2 <= c_p2;
						link.cmd_len <= hwdata[`SCST_CMD_LEN];
						// data bytes only follow a command block
						tx_left <= (c_p2 == `SCST_P2_CMD) ?
							hwdata[`SCST_CMD_LEN] : 8'h00;
					end
				end else if (!ph_write && ph_addr == `SCST_A_STAT) begin
					hrdata[`SCST_ST_SW] <= sw;
					hrdata[`SCST_ST_BUSY] <= busy;
					hrdata[`SCST_ST_REFUSED] <= refused;
					hrdata[`SCST_ST_RXAV] <= rx_full;
				end else if (!ph_write && ph_addr == `SCST_A_DATA) begin
					hrdata[7:0] <= rx_full ? rx_byte : 8'h00;
				end
			end
		end
	end

	// busy from issue to the card's done, status words kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			sw <= 16'h0000;
		end else if (link.done) begin
			busy <= 1'b0;
			sw <= {link.sw1, link.sw2};
		end else if (link.cmd_start) begin
			busy <= 1'b1;
		end
	end

	// one-byte response holder; a full holder stalls the card
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_full <= 1'b0;
			rx_byte <= 8'h00;
			link.rsp_ready <= 1'b1;
		end else if (link.rsp_valid && link.rsp_ready) begin
			rx_full <= 1'b1;
			rx_byte <= link.rsp_data;
			link.rsp_ready <= 1'b0;
		end else if (ph_valid && !ph_write && ph_addr == `SCST_A_DATA) begin
			rx_full <= 1'b0;
			link.rsp_ready <= 1'b1;
		end
	end
endmodule

// >>> scst_link_asserts.sv
// concurrent checks on the command link between terminal and card
`timescale 1ns/1ps
`include "scst_defs.svh"
module scst_link_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cmd_start,
	input wire logic [1:0] cmd_chan,
	input wire logic [7:0] cmd_p1,
	input wire logic [7:0] cmd_p2,
	input wire logic [7:0] cmd_len,
	input wire logic tx_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_ready,
	input wire logic done,
	input wire logic [7:0] sw1,
	input wire logic [7:0] sw2
);
	logic [7:0] last_p1;
	logic [1:0] rcnt;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// last command code, so answers can be tied to their command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_p1 <= 8'h00;
		end else if (cmd_start) begin
			last_p1 <= cmd_p1;
		end
	end
	// response bytes taken since the last command; saturates at three
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rcnt <= 2'h0;
		end else if (cmd_start) begin
			rcnt <= 2'h0;
		end else if (rsp_valid && rsp_ready && rcnt != 2'h3) begin
			rcnt <= rcnt + 2'h1;
		end
	end
	sequence s_data_cmd;
		cmd_start && cmd_p2 == `SCST_P2_CMD && cmd_len != 8'h00;
	endsequence
	sequence s_start_cmd;
		cmd_start && cmd_p1 == `SCST_P1_START && cmd_p2 == `SCST_P2_CMD;
	endsequence
	a_start_chan_zero: assert property (s_start_cmd |-> cmd_chan == 2'h0)
		else $error("start command off basic channel");
	a_p2_legal: assert property (cmd_start |->
		cmd_p2 inside {`SCST_P2_CMD, `SCST_P2_RSP})
		else $error("command issued with bad block code");
	a_p1_legal: assert property (cmd_start |->
		cmd_p1 inside {`SCST_P1_START, `SCST_P1_TERM})
		else $error("command issued with bad function code");
	a_tx_opens: assert property (s_data_cmd |=> tx_ready)
		else $error("card not ready for command bytes");
	a_rsp_tag_first: assert property (rsp_valid && rcnt == 2'h0 |->
		rsp_data == `SCST_TAG_RSP)
		else $error("start answer without its tag");
	a_rsp_len_one: assert property (rsp_valid && rcnt == 2'h1 |->
		rsp_data == `SCST_RSP_LEN)
		else $error("start answer length wrong");
	a_rsp_rsvd_zero: assert property (rsp_valid && rcnt == 2'h2 |->
		rsp_data[5:0] == `SCST_RSP_RSVD)
		else $error("reserved session bits set");
	a_rsp_three_max: assert property (rsp_valid |-> rcnt != 2'h3)
		else $error("too many answer bytes");
	a_term_no_data: assert property (rsp_valid |->
		last_p1 == `SCST_P1_START)
		else $error("answer bytes after terminate");
	a_mac_only_term: assert property (done && {sw1, sw2} ==
		`SCST_SW_MAC |-> last_p1 == `SCST_P1_TERM)
		else $error("code error status outside terminate");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data))
		else $error("answer byte dropped before taken");
	a_done_pulse: assert property (done |=> !done)
		else $error("completion longer than one cycle");
endmodule

// >>> scst_link_if.sv
// command link between terminal controller and card
`timescale 1ns/1ps
interface scst_link_if;
	logic cmd_start;
	logic [1:0] cmd_chan;
	logic [7:0] cmd_p1;
	logic [7:0] cmd_p2;
	logic [7:0] cmd_len;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_ready;
	logic done;
	logic [7:0] sw1;
	logic [7:0] sw2;
	modport host(output cmd_start, cmd_chan, cmd_p1, cmd_p2, cmd_len,
		tx_valid, tx_data, rsp_ready,
		input tx_ready, rsp_valid, rsp_data, done, sw1, sw2);
	modport card(input cmd_start, cmd_chan, cmd_p1, cmd_p2, cmd_len,
		tx_valid, tx_data, rsp_ready,
		output tx_ready, rsp_valid, rsp_data, done, sw1, sw2);
endinterface

// >>> scst_pkg.sv
// types shared by both ends of the secure channel command link
package scst_pkg;
	typedef enum logic [2:0] {
		CS_IDLE, CS_RECV, CS_CHECK, CS_ANSWER, CS_SEND
	} scst_card_state_t;
	typedef enum logic [2:0] {
		PS_OTAG, PS_OLEN, PS_OLEN2, PS_TAG, PS_LEN, PS_VAL, PS_BAD
	} scst_parse_state_t;
endpackage

// >>> secure_channel_start_terminate_tb.sv
// self-checking bench: terminal and card joined over the command link
`timescale 1ns/1ps
`include "scst_defs.svh"
module secure_channel_start_terminate_tb import scst_pkg::*;;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, term_valid, term_is_master, bind_valid;
	logic [31:0] hrdata;
	logic [2:0] verdict = 3'h7;
	logic [1:0] xsess = 2'h0;
	logic [1:0] sess = 2'h0;
	logic [127:0] term_ident, term_mac, cident, ccode, id_e, mc_e;
	logic [1:0] bind_session;
	logic [15:0] bind_size, xfer_size;
	logic [7:0] csel, isel;
	// bit 16 is the expected start-success pulse beside the status words
	logic [16:0] exp_sw[$];
	logic [7:0] bq[$];
	logic [7:0] oh[4] = '{8'h01, 8'h02, 8'h04, 8'h80};
	logic mst_e, chk_m;
	int err_total = 0;
	int n_tests = 0;
	scst_link_if link();
	scst_host scst_host_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .link(link));
	scst_card scst_card_inst(.hclk(hclk), .hresetn(hresetn), .link(link),
		.term_valid(term_valid), .term_is_master(term_is_master),
		.term_ident(term_ident), .term_mac(term_mac),
		.term_mac_ok(verdict[1]), .term_exists(verdict[2]),
		.term_done(verdict[0]), .bind_valid(bind_valid),
		.bind_session(bind_session), .bind_size(bind_size),
		.connection_assoc_ident(cident), .start_channel_auth_code(ccode),
		.cipher_select_byte(csel), .integrity_select_byte(isel),
		.xfer_session(xsess), .xfer_size(xfer_size));
	scst_link_asserts scst_link_asserts_inst(.hclk(hclk),
		.hresetn(hresetn), .cmd_start(link.cmd_start),
		.cmd_chan(link.cmd_chan), .cmd_p1(link.cmd_p1),
		.cmd_p2(link.cmd_p2), .cmd_len(link.cmd_len),
		.tx_ready(link.tx_ready), .rsp_valid(link.rsp_valid),
		.rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready),
		.done(link.done), .sw1(link.sw1), .sw2(link.sw2));
	always #10 hclk = ~hclk;
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one single ahb-lite word transfer; waits on hready, no fixed latency
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask
	task automatic stat_wait();
		logic [31:0] r;
		r = 32'h1 << `SCST_ST_BUSY;
		while (r[`SCST_ST_BUSY] !== 1'b0) ahb(1'b0, `SCST_A_STAT, 32'h0, r);
	endtask
	// command write, its whole byte stream, then wait until idle
	task automatic send(input logic [7:0] p1, input logic [7:0] p2);
		logic [31:0] r;
		ahb(1'b1, `SCST_A_CMD, {8'h0, 8'(bq.size()), p2, p1}, r);
		foreach (bq[i]) ahb(1'b1, `SCST_A_DATA, {24'h0, bq[i]}, r);
		bq.delete();
		stat_wait();
	endtask
	task automatic push16(input logic [127:0] v);
		for (int i = 15; i >= 0; i--) bq.push_back(v[8*i +: 8]);
	endtask
	// response fetch: n answer bytes expected, then nothing left over
	task automatic fetch(input logic [7:0] p1, input int n);
		logic [31:0] r;
		logic [7:0] eb[3];
		eb = '{`SCST_TAG_RSP, 8'h01, {sess, 6'h00}};
		exp_sw.push_back({1'b0, `SCST_SW_OK});
		ahb(1'b1, `SCST_A_CMD, {8'h0, 8'(n), `SCST_P2_RSP, p1}, r);
		for (int k = 0; k < n; k++) begin
			r = 32'h0;
			while (r[`SCST_ST_RXAV] !== 1'b1) ahb(1'b0, `SCST_A_STAT, 0, r);
			ahb(1'b0, `SCST_A_DATA, 32'h0, r);
			chk(r[7:0], eb[k]);
		end
		stat_wait();
		ahb(1'b0, `SCST_A_STAT, 32'h0, r);
		chk(r[`SCST_ST_RXAV], 1'b0);
	endtask
	task automatic start(input logic [7:0] c, input logic [7:0] g,
		input logic [15:0] sw);
		logic [7:0] sz;
		sz = 8'($urandom_range(255, 1));
		id_e = {$urandom, $urandom, $urandom, $urandom};
		mc_e = {$urandom, $urandom, $urandom, $urandom};
		bq = '{8'h73, 8'h2b, 8'h89, 8'h02, c, g, 8'h8b, 8'h10};
		push16(id_e);
		bq.push_back(8'h8d);
		bq.push_back(8'h10);
		push16(mc_e);
		bq = {bq, 8'h8e, 8'h01, sz};
		exp_sw.push_back({sw == `SCST_SW_OK, sw});
		send(`SCST_P1_START, `SCST_P2_CMD);
		if (sw == `SCST_SW_OK) begin
			chk({bind_session, bind_size}, {sess, 8'h0, sz});
			chk(cident, id_e);
			chk(ccode, mc_e);
			chk({csel, isel}, {c, g});
			fetch(`SCST_P1_START, 3);
			xsess <= sess;
			repeat (3) @(posedge hclk);
			chk(xfer_size, {8'h0, sz});
			sess = sess + 2'h1;
		end
	endtask
	// terminate n objects, first tag t1, rest t2; v sets card verdicts
	task automatic term(input logic [7:0] t1, input logic [7:0] t2,
		input int n, input logic [2:0] v, input logic [15:0] sw);
		id_e = {$urandom, $urandom, $urandom, $urandom};
		mc_e = {$urandom, $urandom, $urandom, $urandom};
		mst_e = (t1 == `SCST_TAG_MSA);
		chk_m = (t1 == t2);
		verdict <= v;
		bq = '{8'h73, 8'(34 * n)};
		for (int j = 0; j < n; j++) begin
			bq = {bq, (j == 0) ? t1 : t2, 8'h20};
			push16(id_e);
			push16(mc_e);
		end
		exp_sw.push_back({1'b0, sw});
		send(`SCST_P1_TERM, `SCST_P2_CMD);
	endtask
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test();
		if (exp_sw.size() != 0) err_total++;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// oldest noted status word against each completion pulse
	always @(posedge hclk) begin
		if (link.done === 1'b1) begin
			if (exp_sw.size() == 0) begin
				err_total++;
				$display("[FAIL] %0t completion not expected", $time);
			end else begin
				chk({bind_valid, link.sw1, link.sw2}, exp_sw.pop_front());
			end
		end
	end
	// every parsed terminate object must carry the sent ident and code
	always @(posedge hclk) begin
		if (term_valid === 1'b1) begin
			chk(term_ident, id_e);
			chk(term_mac, mc_e);
			if (chk_m) chk(term_is_master, mst_e);
		end
	end
	initial begin
		// the whole sequence needs some 4300 cycles
		repeat (20000) @(posedge hclk);
		err_total++;
		finish_test();
	end
	initial begin
		logic [31:0] r;
		logic [7:0] bad[6][2];
		logic [31:0] refuse[4];
		bad = '{'{8'h03, 8'h01}, '{8'h08, 8'h01}, '{8'h00, 8'h01},
			'{8'h01, 8'h06}, '{8'h01, 8'h40}, '{8'h01, 8'h00}};
		// channel sits in bits 25:24, so the command word is full width
		refuse = '{32'h0100_8003, 32'h0000_8005, 32'h0000_0003,
			32'h0000_8104};
		void'($urandom(80));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, `SCST_A_STAT, 32'h0, r);
		chk(r[15:0], 16'h0000);
		ahb(1'b1, 8'h0c, 32'hffff_ffff, r);
		ahb(1'b0, 8'h0c, 32'h0, r);
		chk(r, 32'h0);
		end_test("reset and map");
		// refused: off-channel start, bad function code, bad block code
		foreach (refuse[i]) begin
			ahb(1'b1, `SCST_A_CMD, refuse[i], r);
			ahb(1'b0, `SCST_A_STAT, 32'h0, r);
			chk(r[`SCST_ST_REFUSED], 1'b1);
		end
		end_test("refusals");
		for (int i = 0; i < 4; i++) start(oh[i], oh[3 - i], `SCST_SW_OK);
		end_test("start codes");
		foreach (bad[i]) start(bad[i][0], bad[i][1], `SCST_SW_DATA);
		start(8'h04, 8'h80, `SCST_SW_OK);
		end_test("bad selection");
		term(8'h88, 8'h88, 1, 3'b111, `SCST_SW_OK);
		term(8'h88, 8'h88, 1, 3'b101, `SCST_SW_MAC);
		term(8'h8b, 8'h8b, 2, 3'b010, `SCST_SW_OK);
		term(8'h8b, 8'h8b, 2, 3'b110, `SCST_SW_FAIL);
		term(8'h88, 8'h8b, 2, 3'b111, `SCST_SW_DATA);
		fetch(`SCST_P1_TERM, 0);
		end_test("terminate");
		repeat (4) @(posedge hclk);
		finish_test();
	end
endmodule
